// ==== design/frpc_host.sv ====
// host sequencer for flash register read/write and page program commands
// Contract
// R1 - opcode 05h reads status one on one line, no address or dummy, repeating while clocked.
// R2 - opcode 35h reads status two on one line, no address or dummy, repeating while clocked.
// R3 - opcode B5h sends 3 or 4 address bytes, 8 dummy clocks, then one nonvolatile byte.
// R4 - opcode 85h sends 3 or 4 address bytes, 8 dummy clocks, then one volatile byte.
// R5 - opcode C8h reads the extended address byte on one line, repeating while clocked.
// R6 - opcode 01h is followed directly by exactly one data byte on one line.
// R7 - opcode 31h is followed directly by exactly one data byte on one line.
// R8 - opcode B1h sends 3 or 4 address bytes and one data byte, no dummy.
// R9 - opcode 81h sends 3 or 4 address bytes and one data byte, no dummy.
// R10 - opcode C5h is followed by one data byte on one line, no address or dummy.
// R11 - opcode 02h sends 3 or 4 address bytes then 1 to 256 data bytes on one line.
// R12 - opcode 12h always sends 4 address bytes then 1 to 256 data bytes on one line.
// R13 - opcode 34h sends opcode and 4 address bytes on one line, 1 to 256 data bytes on four.
// R14 - widths name lines for opcode, address and data; zero is absent, brackets are device data.
// R15 - the three-or-four address length is three, or four while 4-byte mode is on.
// R16 - data is sampled on rising serial clock edges and changed so it is stable for them.
`timescale 1ns/100ps
module frpc_host
    import frpc_pkg::*;
(
    input wire logic core_clk, // core clock, 100 MHz
    input wire logic rst, // async reset, active high
    input wire logic cmd_valid, // command request
    input wire logic [7:0] cmd_op, // opcode
    input wire logic [31:0] cmd_addr, // address, low 24 bits in 3-byte mode
    input wire logic cmd_addr4, // 4-byte address mode is active
    input wire logic [8:0] cmd_len, // data bytes for streams and programs
    output logic cmd_ready, // idle, command may be taken
    input wire logic wr_valid, // write byte present
    input wire logic [7:0] wr_data, // write byte
    output logic wr_taken, // pulse: write byte was taken
    output logic rd_valid, // pulse: read byte on rd_data
    output logic [7:0] rd_data, // read byte
    output logic cmd_done, // pulse: frame finished
    output logic cmd_err, // pulse: command refused
    output logic sclk, // serial clock
    output logic cs_n, // chip select, active low
    output logic [3:0] io_o, // data pin outputs
    output logic [3:0] io_oe, // data pin enables
    input wire logic [3:0] io_i // data pin inputs
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    typedef struct packed {
        frpc_state_t st;
        logic [7:0] op;
        frpc_info_t info;
        logic [31:0] a;
        logic [2:0] nab;
        logic [8:0] left;
        logic pend;
        logic [2:0] cnt;
        logic [3:0] s1;
        logic [3:0] s2;
        logic go;
        logic [7:0] tx;
        logic quad;
        logic drive;
        logic cmd_ready;
        logic wr_taken;
        logic rd_valid;
        logic [7:0] rd_data;
        logic done;
        logic err;
        logic cs_n;
    } frpc_top_t;

    frpc_top_t q, d;
    frpc_if bus ();
    frpc_info_t inf;
    logic bad;

    frpc_shift frpc_shift_inst (
        .core_clk(core_clk),
        .rst(rst),
        .bus(bus.eng),
        .sclk(sclk),
        .io_o(io_o),
        .io_oe(io_oe)
    );

    always_comb
    begin
        d = q;
        d.go = 1'b0;
        d.wr_taken = 1'b0;
        d.rd_valid = 1'b0;
        d.done = 1'b0;
        d.err = 1'b0;
        d.s1 = io_i;
        d.s2 = q.s1;
        inf = frpc_decode(cmd_op, cmd_addr4); // R15
        bad = !inf.ok || (inf.multi && (cmd_len == 9'h000 || (!inf.rd && cmd_len > PAGE_MAX)));
        unique case (q.st)
            FRPC_IDLE:
            begin
                d.cmd_ready = 1'b1;
                d.cs_n = 1'b1;
                if (cmd_valid && q.cmd_ready)
                begin
                    d.cmd_ready = 1'b0;
                    if (bad)
                    begin
                        // refused: no frame, chip select stays high
                        d.err = 1'b1;
                    end
                    else
                    begin
                        // opcode always on one line
                        d.st = FRPC_HDR;
                        d.cs_n = 1'b0;
                        d.op = cmd_op;
                        d.info = inf;
                        d.nab = inf.ab; // R15
                        d.a = (inf.ab == ADDR_B4) ? cmd_addr : {cmd_addr[23:0], 8'h00};
                        d.left = inf.multi ? cmd_len : ONE_BYTE; // R11 R12 R13
                        d.go = 1'b1;
                        d.tx = cmd_op;
                        d.quad = 1'b0; // R14
                        d.drive = 1'b1;
                    end
                end
            end
            FRPC_HDR:
            begin
                if (bus.done)
                begin
                    d.go = 1'b1;
                    d.quad = 1'b0;
                    if (q.nab != ADDR_NONE)
                    begin
                        // address bytes go out msb first on one line
                        d.tx = q.a[31:24]; // R3 R4 R8 R9 R11 R12 R13
                        d.a = {q.a[23:0], 8'h00};
                        d.nab = q.nab - 3'h1;
                        d.drive = 1'b1;
                    end
                    else if (q.info.dummy)
                    begin
                        d.tx = DUMMY_BYTE; // R3 R4
                        d.drive = 1'b0;
                        d.info.dummy = 1'b0;
                    end
                    else if (q.info.rd)
                    begin
                        d.tx = DUMMY_BYTE; // R1 R2 R5
                        d.drive = 1'b0;
                        d.st = FRPC_RD;
                    end
                    else
                    begin
                        d.go = 1'b0;
                        d.pend = 1'b0;
                        d.st = FRPC_WR; // R6 R7 R10
                    end
                end
            end
            FRPC_RD:
            begin
                if (bus.done)
                begin
                    d.rd_valid = 1'b1;
                    d.rd_data = bus.rx; // R14
                    if (q.left == ONE_BYTE)
                    begin
                        d.st = FRPC_ENDF;
                        d.cnt = '0;
                    end
                    else
                    begin
                        // keep clocking to receive the repeated register byte
                        d.left = q.left - 9'h001; // R1 R2 R5
                        d.go = 1'b1;
                        d.tx = DUMMY_BYTE;
                        d.drive = 1'b0;
                    end
                end
            end
            FRPC_WR:
            begin
                if (q.pend)
                begin
                    if (bus.done)
                    begin
                        d.pend = 1'b0;
                        if (q.left == ONE_BYTE)
                        begin
                            d.st = FRPC_ENDF;
                            d.cnt = '0;
                        end
                        else
                        begin
                            d.left = q.left - 9'h001;
                        end
                    end
                end
                else if (wr_valid)
                begin
                    // clock waits low while the byte source stalls
                    d.wr_taken = 1'b1;
                    d.pend = 1'b1;
                    d.go = 1'b1;
                    d.tx = wr_data;
                    d.quad = q.info.quad; // R13
                    d.drive = 1'b1;
                end
            end
            FRPC_ENDF:
            begin
                d.cnt = q.cnt + 3'h1;
                // chip select rises five core cycles after the last fall, one more than half a clock
                if (q.cnt == HALF_LAST)
                    d.cs_n = 1'b1;
                if (q.cnt == CS_HIGH_LAST)
                begin
                    d.done = 1'b1;
                    d.cmd_ready = 1'b1;
                    d.st = FRPC_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            q <= '0;
            q.cs_n <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign bus.go = q.go;
    assign bus.tx = q.tx;
    assign bus.quad = q.quad;
    assign bus.drive = q.drive;
    assign bus.io_s = q.s2;
    assign cmd_ready = q.cmd_ready;
    assign wr_taken = q.wr_taken;
    assign rd_valid = q.rd_valid;
    assign rd_data = q.rd_data;
    assign cmd_done = q.done;
    assign cmd_err = q.err;
    assign cs_n = q.cs_n;

    // helper: rising serial clock edges and data bytes in the current frame
    logic sclk_p;
    logic [15:0] edges;
    logic [15:0] len_h;
    logic [15:0] ab_h;
    logic [8:0] bytes_h;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sclk_p <= 1'b0;
            edges <= 16'h0000;
            len_h <= 16'h0000;
            bytes_h <= 9'h000;
        end
        else
        begin
            sclk_p <= sclk;
            if (q.st == FRPC_IDLE && q.done == 1'b0)
                edges <= 16'h0000;
            else if (sclk && !sclk_p)
                edges <= edges + 16'h0001;
            if (cmd_valid && q.cmd_ready)
                len_h <= {7'h00, cmd_len};
            if (q.st == FRPC_IDLE && q.done == 1'b0)
                bytes_h <= 9'h000;
            else if (q.wr_taken || q.rd_valid)
                bytes_h <= bytes_h + 9'h001;
        end
    end

    assign ab_h = {13'h0000, q.info.ab};

    // clock counts per frame follow the opcode, address and data widths
    AST_RD_SR1: assert property (q.done && q.op == OP_RD_SR1 |-> edges == 16'h0008 + (len_h << 3)) // R1
        else $error("status one read has wrong clock count");
    AST_RD_SR2: assert property (q.done && q.op == OP_RD_SR2 |-> edges == 16'h0008 + (len_h << 3)) // R2
        else $error("status two read has wrong clock count");
    AST_RD_NVCFG: assert property (q.done && q.op == OP_RD_NVCFG |-> edges == 16'h0018 + (ab_h << 3)) // R3
        else $error("nonvolatile read has wrong clock count");
    AST_RD_VCFG: assert property (q.done && q.op == OP_RD_VCFG |-> edges == 16'h0018 + (ab_h << 3)) // R4
        else $error("volatile read has wrong clock count");
    AST_RD_EXTADR: assert property ($rose(q.done) && q.op == OP_RD_EXTADR |-> edges == 16'h0008 + (len_h << 3)) // R5
        else $error("extended address read has wrong clock count");
    AST_WR_SR1: assert property (q.done && q.op == OP_WR_SR1 |-> edges == 16'h0010) // R6
        else $error("status one write is not sixteen clocks");
    AST_WR_SR2: assert property (q.done && q.op == OP_WR_SR2 |-> edges == 16'h0010) // R7
        else $error("status two write is not sixteen clocks");
    AST_WR_NVCFG: assert property (q.done && q.op == OP_WR_NVCFG |-> edges == 16'h0010 + (ab_h << 3)) // R8
        else $error("nonvolatile write has wrong clock count");
    AST_WR_VCFG: assert property (q.done && q.op == OP_WR_VCFG |-> edges == 16'h0010 + (ab_h << 3)) // R9
        else $error("volatile write has wrong clock count");
    AST_WR_EXTADR: assert property (q.done && q.op == OP_WR_EXTADR |-> edges == 16'h0010) // R10
        else $error("extended address write is not sixteen clocks");
    AST_PROG: assert property (q.done && q.op == OP_PROG |-> edges == 16'h0008 + ((ab_h + len_h) << 3)) // R11
        else $error("page program has wrong clock count");
    AST_PROG4: assert property (q.done && q.op == OP_PROG4 |-> edges == 16'h0028 + (len_h << 3)) // R12
        else $error("4-byte page program has wrong clock count");
    AST_QPROG4: assert property (q.done && q.op == OP_QPROG4 |-> edges == 16'h0028 + (len_h << 1)) // R13
        else $error("quad page program has wrong clock count");
    AST_HDR_ONE_LINE: assert property (q.st == FRPC_HDR |-> io_oe == 4'h0 || io_oe == 4'h1) // R14
        else $error("header phase drove more than one line");
    AST_ADDR_LEN: assert property (cmd_valid && q.cmd_ready && cmd_op == OP_RD_NVCFG
        |=> q.nab == (cmd_addr4 ? ADDR_B4 : ADDR_B3) ##1 q.st == FRPC_HDR) // R15
        else $error("address length does not follow 4-byte mode");

    // line usage and byte counts per phase
    AST_IDLE_LOW: assert property (q.cs_n |-> !sclk) // R16
        else $error("serial clock high while deselected");
    AST_ENDF_QUIET: assert property (q.st == FRPC_ENDF |-> !sclk && io_oe == 4'h0) // R16
        else $error("lines moved after the last clock");
    AST_RD_RELEASED: assert property (q.st == FRPC_RD |-> io_oe == 4'h0) // R1 R2 R5 R14
        else $error("host drove a line during read data");
    AST_QUAD_DATA: assert property (io_oe == 4'hF |-> q.op == OP_QPROG4 && q.st == FRPC_WR) // R13
        else $error("four lines driven outside quad program data");
    AST_WR_DRIVEN: assert property (!q.info.rd && !q.cs_n && sclk |-> io_oe != 4'h0) // R8 R9 R11
        else $error("write command clocked with lines released");
    AST_HDR_DRIVEN: assert property (q.st == FRPC_HDR && sclk && q.nab != ADDR_NONE // R11 R15
        |-> io_oe == 4'h1)
        else $error("address clocked with the line released");
    AST_ERR_NO_FRAME: assert property (q.err |-> q.cs_n && !sclk) // R11 R13
        else $error("refused command moved the pins");
    AST_CFG_ONE_BYTE: assert property (q.rd_valid && !q.info.multi |-> q.st == FRPC_ENDF) // R3 R4
        else $error("configuration read returned more than one byte");
    AST_RD_DATA_HOLD: assert property ($changed(q.rd_data) |-> q.rd_valid) // R1 R2 R5
        else $error("read data changed without a read strobe");
    AST_BYTE_COUNT: assert property (q.done |-> // R1 R2 R5 R11 R12 R13
        bytes_h == (q.info.multi ? len_h[8:0] : ONE_BYTE))
        else $error("frame moved the wrong number of data bytes");

    COV_STREAM: cover property (q.rd_valid && q.op == OP_RD_SR1 ##[1:200] q.rd_valid);
    COV_QUAD: cover property (q.done && q.op == OP_QPROG4);
    COV_ADDR4_READ: cover property (q.done && q.op == OP_RD_VCFG && q.info.ab == ADDR_B4);
    COV_ERR: cover property (q.err);
    COV_ADDR4_PROG: cover property (q.done && q.op == OP_PROG && q.info.ab == ADDR_B4);
endmodule

// ==== design/frpc_pkg.sv ====
// constants, types and opcode decode for the flash register and program host
package frpc_pkg;
    localparam logic [7:0] OP_RD_SR1 = 8'h05;
    localparam logic [7:0] OP_RD_SR2 = 8'h35;
    localparam logic [7:0] OP_RD_NVCFG = 8'hB5;
    localparam logic [7:0] OP_RD_VCFG = 8'h85;
    localparam logic [7:0] OP_RD_EXTADR = 8'hC8;
    localparam logic [7:0] OP_WR_SR1 = 8'h01;
    localparam logic [7:0] OP_WR_SR2 = 8'h31;
    localparam logic [7:0] OP_WR_NVCFG = 8'hB1;
    localparam logic [7:0] OP_WR_VCFG = 8'h81;
    localparam logic [7:0] OP_WR_EXTADR = 8'hC5;
    localparam logic [7:0] OP_PROG = 8'h02;
    localparam logic [7:0] OP_PROG4 = 8'h12;
    localparam logic [7:0] OP_QPROG4 = 8'h34;
    localparam logic [7:0] DUMMY_BYTE = 8'h00;
    // serial clock half period in core cycles is HALF_LAST + 1
    localparam logic [2:0] HALF_LAST = 3'h3;
    localparam logic [2:0] CS_HIGH_LAST = 3'h7;
    localparam logic [3:0] BITS_SINGLE = 4'h8;
    localparam logic [3:0] BITS_QUAD = 4'h2;
    localparam logic [2:0] ADDR_B3 = 3'h3;
    localparam logic [2:0] ADDR_B4 = 3'h4;
    localparam logic [2:0] ADDR_NONE = 3'h0;
    localparam logic [8:0] PAGE_MAX = 9'h100;
    localparam logic [8:0] ONE_BYTE = 9'h001;

    typedef enum logic [2:0] {
        FRPC_IDLE = 3'b000,
        FRPC_HDR = 3'b001,
        FRPC_RD = 3'b010,
        FRPC_WR = 3'b011,
        FRPC_ENDF = 3'b100
    } frpc_state_t;

    typedef struct packed {
        logic ok;
        logic [2:0] ab;
        logic dummy;
        logic rd;
        logic quad;
        logic multi;
    } frpc_info_t;

    function automatic frpc_info_t frpc_decode(input logic [7:0] op, input logic a4);
        frpc_info_t i;
        logic [2:0] ab;
        i = '0;
        ab = a4 ? ADDR_B4 : ADDR_B3;
        case (op)
            OP_RD_SR1, OP_RD_SR2, OP_RD_EXTADR:
            begin
                i.ok = 1'b1;
                i.rd = 1'b1;
                i.multi = 1'b1;
            end
            OP_RD_NVCFG, OP_RD_VCFG:
            begin
                i.ok = 1'b1;
                i.ab = ab;
                i.dummy = 1'b1;
                i.rd = 1'b1;
            end
            OP_WR_SR1, OP_WR_SR2, OP_WR_EXTADR:
            begin
                i.ok = 1'b1;
            end
            OP_WR_NVCFG, OP_WR_VCFG:
            begin
                i.ok = 1'b1;
                i.ab = ab;
            end
            OP_PROG:
            begin
                i.ok = 1'b1;
                i.ab = ab;
                i.multi = 1'b1;
            end
            OP_PROG4, OP_QPROG4:
            begin
                i.ok = 1'b1;
                i.ab = ADDR_B4;
                i.multi = 1'b1;
                i.quad = (op == OP_QPROG4);
            end
            default:
            begin
                i = '0;
            end
        endcase
        return i;
    endfunction
endpackage

// ==== design/frpc_if.sv ====
// byte request and answer between the sequencer and the serial engine
`timescale 1ns/100ps
interface frpc_if;
    logic go;
    logic [7:0] tx;
    logic quad;
    logic drive;
    logic [3:0] io_s;
    logic done;
    logic [7:0] rx;
    modport ctl (output go, output tx, output quad, output drive, output io_s,
        input done, input rx);
    modport eng (input go, input tx, input quad, input drive, input io_s,
        output done, output rx);
endinterface

// ==== design/frpc_shift.sv ====
// serial engine: one byte per request on one or four lines, mode 0 clocking
`timescale 1ns/100ps
module frpc_shift
    import frpc_pkg::*;
(
    input wire logic core_clk, // core clock
    input wire logic rst, // async reset, active high
    frpc_if.eng bus, // byte requests
    output logic sclk, // serial clock pin
    output logic [3:0] io_o, // data pin outputs
    output logic [3:0] io_oe // data pin enables
);
    typedef struct packed {
        logic busy;
        logic high;
        logic [2:0] cnt;
        logic [3:0] bits;
        logic quad;
        logic [7:0] sh;
        logic [7:0] rx;
        logic done;
        logic sclk;
        logic [3:0] io_o;
        logic [3:0] io_oe;
    } frpc_eng_t;

    frpc_eng_t q, d;

    function automatic logic [3:0] lead(input logic [7:0] v, input logic qd);
        return qd ? v[7:4] : {3'h0, v[7]};
    endfunction

    function automatic logic [7:0] shl(input logic [7:0] v, input logic qd);
        return qd ? {v[3:0], 4'h0} : {v[6:0], 1'b0};
    endfunction

    always_comb
    begin
        d = q;
        d.done = 1'b0;
        if (!q.busy)
        begin
            if (bus.go)
            begin
                d.busy = 1'b1;
                d.high = 1'b0;
                d.cnt = '0;
                d.quad = bus.quad;
                d.bits = bus.quad ? BITS_QUAD : BITS_SINGLE;
                d.io_o = lead(bus.tx, bus.quad);
                d.sh = shl(bus.tx, bus.quad);
                d.io_oe = !bus.drive ? 4'h0 : (bus.quad ? 4'hF : 4'h1);
            end
        end
        else if (q.cnt != HALF_LAST)
        begin
            d.cnt = q.cnt + 3'h1;
        end
        else
        begin
            d.cnt = '0;
            if (!q.high)
            begin
                d.high = 1'b1;
                d.sclk = 1'b1;
            end
            else
            begin
                // sample at the end of the high phase; the device changes on the fall
                d.high = 1'b0;
                d.sclk = 1'b0;
                d.rx = q.quad ? {q.rx[3:0], bus.io_s} : {q.rx[6:0], bus.io_s[1]}; // R16
                if (q.bits == 4'h1)
                begin
                    d.busy = 1'b0;
                    d.done = 1'b1;
                    d.io_oe = 4'h0;
                end
                else
                begin
                    d.bits = q.bits - 4'h1;
                    d.io_o = lead(q.sh, q.quad); // R16
                    d.sh = shl(q.sh, q.quad);
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            q <= '0;
        else
            q <= d;
    end

    assign bus.done = q.done;
    assign bus.rx = q.rx;
    assign sclk = q.sclk;
    assign io_o = q.io_o;
    assign io_oe = q.io_oe;

    AST_STABLE_HIGH: assert property (@(posedge core_clk) disable iff (rst)
        (q.sclk && $past(q.sclk)) |-> $stable(q.io_o) && $stable(q.io_oe)) // R16
        else $error("data lines moved while serial clock high");
endmodule

// ==== dv/frpc_flash_model.sv ====
// behavioural serial flash answering register and program commands
`timescale 1ns/100ps
module frpc_flash_model
(
    input wire logic sclk, // serial clock from host
    input wire logic cs_n, // chip select, active low
    input wire logic [3:0] io_o, // host pin outputs
    input wire logic [3:0] io_oe, // host pin enables
    input wire logic a4, // 4-byte address mode active
    output logic [3:0] io_i // pin levels seen by host
);
    logic [7:0] op, wb, rb, sr1, sr2, nvc, vcf, ext;
    logic [31:0] adr;
    logic [3:0] lvl;
    logic rd, qd, den, dbit;
    int n, h, ab, frames;
    logic [7:0] wlog [$];
    initial
    begin
        {sr1, sr2, nvc, vcf, ext, den, dbit, frames} = '0;
    end
    // wire level from the host's enables only
    assign lvl = (io_oe & io_o) | (~io_oe & io_i);
    // a released line shows the inverse of the last bit
    assign io_i = den ? {4{dbit}} : {4{~dbit}};
    always @(negedge cs_n)
    begin
        {n, ab, rd, qd, adr, op} = '0;
        h = 8;
        frames++;
        wlog.delete();
    end
    always @(posedge sclk)
    begin
        if (!cs_n && n < 8)
            op = {op[6:0], lvl[0]};
        else if (!cs_n && n < 8 + 8 * ab)
            adr = {adr[30:0], lvl[0]};
        else if (!cs_n && n >= h && !rd)
        begin
            wb = qd ? {wb[3:0], lvl} : {wb[6:0], lvl[0]};
            if ((n - h + 1) % (qd ? 2 : 8) == 0)
                wlog.push_back(wb);
        end
        n++;
        if (n == 8)
        begin
            rd = op inside {8'h05, 8'h35, 8'hC8, 8'hB5, 8'h85};
            qd = op == 8'h34;
            ab = (op inside {8'h12, 8'h34} || a4) ? 4 : 3;
            if (op inside {8'h05, 8'h35, 8'hC8, 8'h01, 8'h31, 8'hC5})
                ab = 0;
            h = 8 + 8 * ab + (op inside {8'hB5, 8'h85} ? 8 : 0);
            rb = op == 8'h05 ? sr1 : op == 8'h35 ? sr2 : op == 8'hC8 ? ext
                : op == 8'hB5 ? nvc : vcf;
        end
    end
    always @(negedge sclk)
        if (!cs_n && rd && n >= h)
        begin
            den = 1'b1;
            dbit = rb[7 - ((n - h) % 8)];
        end
    always @(posedge cs_n)
    begin
        den = 1'b0;
        if (wlog.size() > 0)
            case (op)
                8'h01: sr1 = wlog[0];
                8'h31: sr2 = wlog[0];
                8'hB1: nvc = wlog[0];
                8'h81: vcf = wlog[0];
                8'hC5: ext = wlog[0];
                default: ;
            endcase
    end
endmodule

// ==== dv/frpc_host_tb.sv ====
// self-checking bench for the flash register and program host
`timescale 1ns/100ps
module frpc_host_tb;
    import frpc_pkg::*;
    logic core_clk = 0, rst = 1, cmd_valid = 0, cmd_addr4 = 0, wr_valid = 0;
    logic [7:0] cmd_op = 0, wr_data = 0, rd_data;
    logic [31:0] cmd_addr = 0;
    logic [8:0] cmd_len = 0;
    logic cmd_ready, wr_taken, rd_valid, cmd_done, cmd_err, sclk, cs_n, saw_err;
    logic [3:0] io_o, io_oe, io_i;
    logic [7:0] wq [$], rq [$];
    int err_count = 0, check_count = 0, wn;
    always #5 core_clk = ~core_clk;
    frpc_host frpc_host_inst (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_addr4(cmd_addr4), .cmd_len(cmd_len),
        .cmd_ready(cmd_ready), .wr_valid(wr_valid), .wr_data(wr_data), .wr_taken(wr_taken),
        .rd_valid(rd_valid), .rd_data(rd_data), .cmd_done(cmd_done), .cmd_err(cmd_err),
        .sclk(sclk), .cs_n(cs_n), .io_o(io_o), .io_oe(io_oe), .io_i(io_i));
    frpc_flash_model frpc_flash_model_inst (.sclk(sclk), .cs_n(cs_n), .io_o(io_o),
        .io_oe(io_oe), .a4(cmd_addr4), .io_i(io_i));
    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one command: feed wq as write bytes, gather read bytes into rq
    task automatic xfer(input logic [7:0] op, input logic [31:0] ad, input logic a4,
        input logic [8:0] ln);
        int k;
        k = 0;
        wn = 0;
        rq.delete();
        @(negedge core_clk);
        {cmd_op, cmd_addr, cmd_addr4, cmd_len, cmd_valid} = {op, ad, a4, ln, 1'b1};
        while (cmd_ready !== 1'b1 && k < 50)
        begin
            @(negedge core_clk);
            k++;
        end
        @(negedge core_clk);
        cmd_valid = 1'b0;
        while (cmd_done !== 1'b1 && cmd_err !== 1'b1 && k < 20000)
        begin
            if (wr_taken === 1'b1)
                wn++;
            if (rd_valid === 1'b1)
                rq.push_back(rd_data);
            wr_valid = wn < wq.size();
            wr_data = wr_valid ? wq[wn] : 8'h00;
            @(negedge core_clk);
            k++;
        end
        wr_valid = 1'b0;
        saw_err = cmd_err === 1'b1;
        if (!saw_err)
            chk({cs_n, sclk}, 2'b10);
        if (k >= 20000)
        begin
            err_count++;
            wrap_up();
        end
    endtask
    task automatic reg_roundtrip();
        logic [7:0] wo [5] = '{OP_WR_SR1, OP_WR_SR2, OP_WR_EXTADR, OP_WR_NVCFG, OP_WR_VCFG};
        logic [7:0] ro [5] = '{OP_RD_SR1, OP_RD_SR2, OP_RD_EXTADR, OP_RD_NVCFG, OP_RD_VCFG};
        logic [7:0] v [5] = '{8'h5A, 8'hC3, 8'h01, 8'h7E, 8'h96};
        logic a [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
        int nr;
        for (int i = 0; i < 5; i++)
        begin
            nr = i < 3 ? 2 : 1;
            wq = '{v[i]};
            xfer(wo[i], 32'hA1B2_C3D4, a[i], 9'h000);
            chk(wn, 1);
            chk(frpc_flash_model_inst.adr, i < 3 ? 0 : a[i] ? 32'hA1B2_C3D4 : 32'h00B2_C3D4);
            wq.delete();
            xfer(ro[i], 32'hA1B2_C3D4, a[i], 9'(nr));
            chk(rq.size(), nr);
            for (int j = 0; j < nr; j++)
                chk(rq[j], v[i]);
        end
    endtask
    task automatic page_programs();
        logic [7:0] ops [4] = '{OP_PROG, OP_PROG4, OP_QPROG4, OP_PROG};
        int ln [4] = '{1, 3, 256, 2};
        for (int i = 0; i < 4; i++)
        begin
            wq.delete();
            for (int j = 0; j < ln[i]; j++)
                wq.push_back(8'(j) ^ 8'h3C);
            xfer(ops[i], 32'h1234_5678, i == 3, 9'(ln[i]));
            chk(wn, ln[i]);
            chk(frpc_flash_model_inst.wlog.size(), ln[i]);
            for (int j = 0; j < ln[i]; j++)
                chk(frpc_flash_model_inst.wlog[j], wq[j]);
            chk(frpc_flash_model_inst.adr, i == 0 ? 32'h0034_5678 : 32'h1234_5678);
        end
    endtask
    task automatic refusals();
        logic [7:0] ops [4] = '{8'h9F, OP_PROG, OP_QPROG4, OP_RD_SR1};
        logic [8:0] ln [4] = '{9'h001, 9'h000, 9'h101, 9'h000};
        int f;
        wq.delete();
        for (int i = 0; i < 4; i++)
        begin
            f = frpc_flash_model_inst.frames;
            xfer(ops[i], 32'h0000_0000, 1'b0, ln[i]);
            chk(saw_err, 1'b1);
            chk(frpc_flash_model_inst.frames, f);
        end
    endtask
    initial
    begin
        repeat (4) @(negedge core_clk);
        rst = 1'b0;
        repeat (2) @(negedge core_clk);
        reg_roundtrip();
        page_programs();
        refusals();
        wrap_up();
    end
endmodule
